// file: srx_rx_if.sv
/*
  Receive channel output side: comma alignment, rate-adapting FIFO,
  mode-dependent status outputs and output clock, APB control.
  Assumes an external combinational decoder on pclk and a serial link
  whose clock and data are asynchronous pins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srx_consts.svh"

// Behaviour
// - Ten-bit mode: valid pin carries bit 8
// - Ten-bit mode: special pin flags error kind
// - Otherwise special pin marks control code group
// - Ten-bit mode: error pin carries bit 9
// - Output clock follows data; half rate ten-bit
// - Inverse clock in ten-bit mode, else low
// - Comma pin set when comma detected
// - Channel off disables the receiver
// - Ten-bit, realign high: realign every comma
// - Ten-bit, realign low: first alignment only
// - Realign input ignored outside ten-bit mode
// - Long frames deepen FIFO in reference mode
// - Channel A clock with recovered mode
// - Word sync: receivers deliver in unison
// - Byte alignment only when enabled
// - Conformant mode adapts outside packets only
// - Loopback takes transmitter data
// - Drop sync with off forces resync
// - Recovered mode times output from link
// - Idle add/delete, ignored in recovered mode
// - Reference mode times output from reference
// - Two comma code groups align
// - Lock after four aligned commas
module srx_rx_if #(
  parameter int DEPTH    = 8,
  parameter int WORD_CYC = `SRX_WORD_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Serial link and loopback
  input  wire logic        link_clk,
  input  wire logic        link_bit,
  input  wire logic        loop_bit,
  // Decoder
  output var  logic [9:0]  dec_char,
  input  wire logic [7:0]  dec_byte,
  input  wire logic        dec_k,
  input  wire logic        dec_err,
  // Timing shared between receivers
  input  wire logic        chan_a_tick,
  input  wire logic        group_word_tick,
  output var  logic        word_tick,
  // Parallel output
  output var  logic [7:0]  rx_byte_out,
  output var  logic        rx_valid_or_bit8,
  output var  logic        rx_ctrl_code_or_error,
  output var  logic        rx_comma_seen,
  output var  logic        rx_error_or_bit9,
  output var  logic        rx_out_clock,
  output var  logic        rx_out_clock_inv
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [15:0] WC_LAST = 16'(WORD_CYC - 1);
  localparam logic [15:0] WC_HALF = 16'(WORD_CYC / 2);

  if (DEPTH < 4 || DEPTH > 64 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk_d
    $error("DEPTH must be a power of two from 4 to 64");
  end
  if (WORD_CYC < 4 || WORD_CYC > 65535) begin : g_chk_w
    $error("WORD_CYC out of range");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [`SRX_CTRL_W-1:0] ctrl_q;
  logic [`SRX_FLAG_W-1:0] flag_q;
  logic [`SRX_FLAG_W-1:0] flag_set;
  logic [2:0]             lclk_q;
  logic [1:0]             lbit_q;
  logic [1:0]             lpb_q;
  logic [9:0]             sr_q;
  logic [3:0]             pos_q;
  logic [2:0]             cnt_q;
  logic                   first_q;
  srx_pkg::srx_align_e    st_q;
  logic                   wv_q;
  logic                   cma_q;
  logic                   in_pkt_q;
  srx_pkg::srx_entry_t    mem_q [DEPTH];
  logic [AW-1:0]          wp_q;
  logic [AW-1:0]          rp_q;
  logic [CW-1:0]          lvl_q;
  logic [15:0]            rc_q;
  logic [15:0]            hc_q;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  wire c_tbi    = ctrl_q[`SRX_C_TBI];
  wire c_realn  = ctrl_q[`SRX_C_REALIGN];
  wire c_long   = ctrl_q[`SRX_C_LONG];
  wire c_use_a  = ctrl_q[`SRX_C_USE_A];
  wire c_ws     = ctrl_q[`SRX_C_WS_LO] | ctrl_q[`SRX_C_WS_HI];
  wire c_balign = ctrl_q[`SRX_C_BALIGN];
  wire c_conf   = ctrl_q[`SRX_C_CONF];
  wire c_loop   = ctrl_q[`SRX_C_LOOP];
  wire c_recovered_clock_mode   = ctrl_q[`SRX_C_RECOVERED_CLOCK_MODE];
  wire c_idle   = ctrl_q[`SRX_C_IDLE];
  wire c_off    = ctrl_q[`SRX_C_OFF];
  wire c_drop   = ctrl_q[`SRX_C_DROP];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire setup    = psel & ~penable;
  wire wr       = psel & penable & pwrite & pready;
  wire hit_ctrl = paddr == `SRX_CTRL_OFS;
  wire hit_stat = paddr == `SRX_STAT_OFS;
  wire hit_flag = paddr == `SRX_FLAG_OFS;
  wire hit_any  = hit_ctrl | hit_stat | hit_flag;
  wire [31:0] stat_word = {16'h0000, 8'(lvl_q), 3'h0, in_pkt_q,
                           first_q, st_q};
  wire [31:0] rd_word =
    hit_ctrl ? {{(32-`SRX_CTRL_W){1'b0}}, ctrl_q} :
    hit_stat ? stat_word :
    hit_flag ? {{(32-`SRX_FLAG_W){1'b0}}, flag_q} : 32'h0000_0000;
  wire [`SRX_FLAG_W-1:0] flag_clr =
    (wr & hit_flag) ? pwdata[`SRX_FLAG_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      ctrl_q  <= `SRX_CTRL_RST;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup) begin
        prdata <= rd_word;
      end
      if (wr & hit_ctrl) begin
        ctrl_q <= pwdata[`SRX_CTRL_W-1:0];
      end
    end
  end

  // Sticky flags, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_q <= 3'h0;
      lbit_q <= 2'h0;
      lpb_q  <= 2'h0;
    end else begin
      lclk_q <= {lclk_q[1:0], link_clk};
      lbit_q <= {lbit_q[0], link_bit};
      lpb_q  <= {lpb_q[0], loop_bit};
    end
  end

  wire bit_en = lclk_q[1] & ~lclk_q[2] & ~c_off;
  wire rx_bit = c_loop ? lpb_q[1] : lbit_q[1];

  // ----------------------------------------------------------------------
  // Comma alignment
  // ----------------------------------------------------------------------
  wire [9:0] sr_d   = {rx_bit, sr_q[9:1]};
  wire comma_now    = (sr_d[6:0] == `SRX_COMMA_P) |
                      (sr_d[6:0] == `SRX_COMMA_N);
  wire at_bnd       = pos_q == 4'd9;
  wire ra_ok        = c_balign &
                      (~c_tbi | c_realn | ~first_q);
  wire realign      = bit_en & comma_now & ~at_bnd & ra_ok;
  wire word_end     = bit_en & (at_bnd | realign);
  wire same_comma   = bit_en & comma_now & at_bnd & c_balign;
  wire lock_now     = same_comma & (cnt_q == `SRX_COMMA_LOCK - 3'h1);
  wire resync       = c_off & c_drop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q     <= 10'h000;
      pos_q    <= 4'h0;
      cnt_q    <= 3'h0;
      first_q  <= 1'b0;
      st_q     <= srx_pkg::SRX_HUNT;
      wv_q     <= 1'b0;
      cma_q    <= 1'b0;
      dec_char <= 10'h000;
    end else begin
      wv_q <= word_end;
      if (bit_en) begin
        sr_q  <= sr_d;
        pos_q <= (at_bnd | realign) ? 4'h0 : pos_q + 4'h1;
      end
      if (word_end) begin
        dec_char <= sr_d;
        cma_q    <= comma_now;
      end
      if (resync) begin
        st_q    <= srx_pkg::SRX_HUNT;
        cnt_q   <= 3'h0;
        first_q <= 1'b0;
      end else if (realign) begin
        st_q  <= srx_pkg::SRX_LOCKING;
        cnt_q <= 3'h1;
      end else if (same_comma && cnt_q < `SRX_COMMA_LOCK) begin
        cnt_q <= cnt_q + 3'h1;
        case (st_q)
          srx_pkg::SRX_HUNT: begin
            st_q <= srx_pkg::SRX_LOCKING;
          end
          srx_pkg::SRX_LOCKING: begin
            if (lock_now) begin
              st_q    <= srx_pkg::SRX_LOCKED;
              first_q <= 1'b1;
            end
          end
          srx_pkg::SRX_LOCKED: begin
            st_q <= srx_pkg::SRX_LOCKED;
          end
          default: begin
            st_q <= srx_pkg::SRX_HUNT;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Rate-adapting FIFO
  // ----------------------------------------------------------------------
  wire [CW-1:0] lim = (c_long & ~c_recovered_clock_mode) ? CW'(DEPTH)
                                         : CW'(DEPTH / 2);
  wire adapt     = c_idle & ~c_recovered_clock_mode;
  wire pkt_start = dec_k & (dec_byte == `SRX_PKT_START);
  wire pkt_end   = dec_k & (dec_byte == `SRX_PKT_END);
  wire movable   = ~c_conf | (~in_pkt_q & ~pkt_start);
  wire push      = wv_q & (lvl_q < lim);
  wire drop_ovr  = wv_q & ~push & ~(adapt & movable);
  wire ref_tick  = rc_q == WC_LAST;
  wire own_tick  = word_tick;
  wire out_tick  = c_ws ? group_word_tick :
                   c_recovered_clock_mode ? (c_use_a ? chan_a_tick
                                     : own_tick) :
                   ref_tick;
  wire empty     = lvl_q == '0;
  wire pop       = out_tick & ~empty;
  wire hold      = out_tick & empty & adapt & movable;
  wire unr       = out_tick & empty & ~hold;
  srx_pkg::srx_entry_t head;
  assign head    = mem_q[rp_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q     <= '0;
      rp_q     <= '0;
      lvl_q    <= '0;
      in_pkt_q <= 1'b0;
      rc_q     <= 16'h0000;
      word_tick <= 1'b0;
    end else begin
      word_tick <= wv_q;
      rc_q      <= ref_tick ? 16'h0000 : rc_q + 16'h0001;
      if (wv_q) begin
        in_pkt_q <= pkt_start | (in_pkt_q & ~pkt_end);
      end
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      lvl_q <= lvl_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= {cma_q, dec_err, dec_k, dec_byte, dec_char};
    end
  end

  assign flag_set = {lock_now, realign, push & dec_err, unr, drop_ovr};

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  wire [9:0] h_char = head[9:0];
  wire [7:0] h_byte = head[17:10];
  wire       h_k    = head[18];
  wire       h_err  = head[19];
  wire       h_cma  = head[20];
  wire [15:0] hc_d  = out_tick ? 16'h0000
                    : (hc_q == 16'hffff ? hc_q : hc_q + 16'h0001);
  wire clk_d = c_tbi ? (out_tick ? ~rx_out_clock : rx_out_clock)
                     : (out_tick ? 1'b0
                        : (hc_q >= WC_HALF ? 1'b1 : rx_out_clock));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc_q                  <= 16'h0000;
      rx_out_clock          <= 1'b0;
      rx_out_clock_inv      <= 1'b0;
      rx_byte_out           <= 8'h00;
      rx_valid_or_bit8      <= 1'b0;
      rx_ctrl_code_or_error <= 1'b0;
      rx_comma_seen         <= 1'b0;
      rx_error_or_bit9      <= 1'b0;
    end else begin
      hc_q             <= hc_d;
      rx_out_clock     <= clk_d;
      rx_out_clock_inv <= c_tbi & ~clk_d;
      if (pop) begin
        rx_comma_seen <= h_cma;
        if (c_tbi) begin
          rx_byte_out           <= h_err ? `SRX_ERR_CODE
                                         : h_char[7:0];
          rx_ctrl_code_or_error <= h_err;
          rx_valid_or_bit8      <= h_char[8];
          rx_error_or_bit9      <= h_char[9];
        end else begin
          rx_byte_out           <= h_byte;
          rx_ctrl_code_or_error <= h_k;
          rx_valid_or_bit8      <= 1'b1;
          rx_error_or_bit9      <= h_err;
        end
      end else if (unr) begin
        rx_comma_seen <= 1'b0;
        if (c_tbi) begin
          rx_byte_out           <= `SRX_ERR_FIFO;
          rx_ctrl_code_or_error <= 1'b1;
        end else begin
          rx_valid_or_bit8      <= 1'b0;
          rx_ctrl_code_or_error <= 1'b0;
          rx_error_or_bit9      <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: srx_consts.svh
/*
  Offsets, field positions, reset values and timing counts for the
  receive data interface control block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SRX_CTRL_OFS    12'h000
`define SRX_STAT_OFS    12'h004
`define SRX_FLAG_OFS    12'h008

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SRX_C_TBI       0
`define SRX_C_REALIGN   1
`define SRX_C_LONG      2
`define SRX_C_USE_A     3
`define SRX_C_WS_LO     4
`define SRX_C_WS_HI     5
`define SRX_C_BALIGN    6
`define SRX_C_CONF      7
`define SRX_C_LOOP      8
`define SRX_C_RECOVERED_CLOCK_MODE      9
`define SRX_C_IDLE      10
`define SRX_C_OFF       11
`define SRX_C_DROP      12
`define SRX_CTRL_W      13
`define SRX_CTRL_RST    13'h0040

// ----------------------------------------------------------------------
// Sticky flag fields (write one to clear)
// ----------------------------------------------------------------------
`define SRX_F_OVR       0
`define SRX_F_UNR       1
`define SRX_F_CERR      2
`define SRX_F_RALN      3
`define SRX_F_LOCK      4
`define SRX_FLAG_W      5

// ----------------------------------------------------------------------
// Code groups, error kinds and alignment
// ----------------------------------------------------------------------
`define SRX_COMMA_P     7'h7c
`define SRX_COMMA_N     7'h03
`define SRX_COMMA_LOCK  3'h4
`define SRX_ERR_CODE    8'h01
`define SRX_ERR_FIFO    8'h02
`define SRX_PKT_START   8'hfb
`define SRX_PKT_END     8'hfd

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SRX_CLK_NS      20
`define SRX_BIT_NS      160
`define SRX_WORD_BITS   10
`define SRX_WORD_CYC    (`SRX_WORD_BITS * `SRX_BIT_NS / `SRX_CLK_NS)

`endif

// file: srx_pkg.sv
/*
  Types for the receive data interface control block.
  Assumes the constants header is compiled alongside.
*/
package srx_pkg;

  typedef enum logic [2:0] {
    SRX_HUNT    = 3'b001,
    SRX_LOCKING = 3'b010,
    SRX_LOCKED  = 3'b100
  } srx_align_e;

  typedef logic [20:0] srx_entry_t;

endpackage

// file: srx_chk.sv
/*
  Port checker for the receive data interface control block.
  Assumes binding into srx_rx_if, whose port names it shares.
*/
`timescale 1ns/100ps
`default_nettype none

module srx_chk #(
  parameter int DEPTH    = 8,
  parameter int WORD_CYC = 80
) (
  // Clock, reset, APB handshake and word tick
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       word_tick,
  // Parallel output
  input wire logic [7:0] rx_byte_out,
  input wire logic       rx_valid_or_bit8,
  input wire logic       rx_ctrl_code_or_error,
  input wire logic       rx_comma_seen,
  input wire logic       rx_error_or_bit9,
  input wire logic       rx_out_clock,
  input wire logic       rx_out_clock_inv
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  wire logic [11:0] outs = {rx_byte_out, rx_valid_or_bit8,
    rx_ctrl_code_or_error, rx_comma_seen, rx_error_or_bit9};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_INV_LOW: assert property (
    rx_out_clock_inv |-> !rx_out_clock)
    else $error("inverse clock high together with clock");
  AST_DATA_CLK: assert property (
    $changed(outs) |-> $changed(rx_out_clock))
    else $error("outputs changed without clock edge");
  AST_CLK_SPACED: assert property (
    $changed(rx_out_clock) |=> $stable(rx_out_clock) [*3])
    else $error("output clock toggles too fast");
  AST_COMMA_CLK: assert property (
    $rose(rx_comma_seen) |-> $changed(rx_out_clock))
    else $error("comma flag raised off the clock");
  AST_TEN_ERR: assert property (
    rx_ctrl_code_or_error && rx_out_clock_inv
      |-> rx_byte_out inside {8'h01, 8'h02})
    else $error("ten-bit error kind not encoded");
  AST_READY_SETUP: assert property (
    psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_TICK: assert property (word_tick |=> !word_tick)
    else $error("word tick longer than one cycle");

  cover property ($rose(rx_comma_seen));
  cover property (pslverr);
  cover property (rx_out_clock_inv && $changed(rx_out_clock));
endmodule

bind srx_rx_if srx_chk #(.DEPTH(DEPTH), .WORD_CYC(WORD_CYC)) u_chk (.*);

`default_nettype wire

// file: srx_link_model.sv
/*
  Far side: serial link source and the combinational decoder.
  Assumes the bench calls send for each burst of characters.
*/
`timescale 1ns/100ps
`default_nettype none

module srx_link_model (
  // Serial link
  output var logic       link_clk,
  output var logic       link_bit,
  output var logic       loop_bit,
  // Decoder
  input wire logic [9:0] dec_char,
  output var logic [7:0] dec_byte,
  output var logic       dec_k,
  output var logic       dec_err
);
  // ------------------------------------------------------------
  // Decoder and link
  // ------------------------------------------------------------
  assign dec_k    = dec_char[6:0] == 7'h7c || dec_char[6:0] == 7'h03;
  assign dec_byte = dec_k ? 8'hbc : dec_char[7:0];
  assign dec_err  = 1'b0;
  assign loop_bit = ~link_bit;

  initial begin
    link_clk = 1'b0;
    link_bit = 1'b0;
  end

  // Clock stands still between bursts; data shows the inverse
  task automatic send(input logic [9:0] w, input int n);
    repeat (n) begin
      for (int i = 0; i < 10; i++) begin
        link_bit = w[i];
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
      end
    end
    link_bit = ~link_bit;
  endtask
endmodule

`default_nettype wire

// file: tb.sv
/*
  Self-checking bench for the receive data interface control block.
  Assumes srx_rx_if, srx_chk and srx_link_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic        pwrite = 0, pready, pslverr, link_clk, link_bit;
  logic        loop_bit, dec_k, dec_err, word_tick;
  logic        rx_valid_or_bit8, rx_ctrl_code_or_error;
  logic        rx_comma_seen, rx_error_or_bit9;
  logic        rx_out_clock, rx_out_clock_inv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [9:0]  dec_char, r;
  logic [7:0]  dec_byte, rx_byte_out;
  logic [31:0] q_e[$], q_m[$];
  int          n_fail = 0, compares = 0, seed = 25354;

  always #10 pclk = ~pclk;

  srx_rx_if #(.DEPTH(8), .WORD_CYC(20)) dut (.*,
    .chan_a_tick(1'b0), .group_word_tick(1'b0));
  srx_link_model lm (.*);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Reads note the expected value; writes carry it
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, m);
    int n;
    n = 0;
    if (!w) begin
      q_e.push_back(d);
      q_m.push_back(m);
    end
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic outs(input logic [9:0] e, input logic k);
    repeat (10) @(posedge pclk);
    chk("data", {22'h0, e},
        {22'h0, rx_error_or_bit9, rx_valid_or_bit8, rx_byte_out});
    chk("special", {31'h0, k}, {31'h0, rx_ctrl_code_or_error});
  endtask

  task automatic conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Read monitor
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", q_e[0], prdata & q_m[0]);
      chk("pslverr", {31'h0, paddr > 12'h008}, {31'h0, pslverr});
      void'(q_e.pop_front());
      void'(q_m.pop_front());
    end
  end

  initial begin
    #200000;
    n_fail++;
    conclude;
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 32'h40, '1);
    apb(0, 12'hffc, 32'h0, '1);
    // Ten-bit, realign, byte align, recovered clock
    apb(1, 12'h000, 32'h243, 0);
    lm.send(10'h17c, 6);
    outs(10'h17c, 0);
    chk("comma", 1, {31'h0, rx_comma_seen});
    chk("inv", {31'h0, ~rx_out_clock}, {31'h0, rx_out_clock_inv});
    apb(0, 12'h004, 32'hc, 32'hf);
    r = 10'($random(seed));
    r = {1'b1, r[3], 1'b0, r[2], 1'b1, r[1], 1'b0, r[0], 2'b10};
    lm.send(r, 1);
    outs(r, 0);
    chk("comma", 0, {31'h0, rx_comma_seen});
    // Byte mode
    apb(1, 12'h000, 32'h240, 0);
    lm.send(10'h17c, 1);
    outs(10'h1bc, 1);
    chk("inv", 0, {31'h0, rx_out_clock_inv});
    lm.send(r, 1);
    outs({2'b01, r[7:0]}, 0);
    // Loopback carries the inverse of the link
    apb(1, 12'h000, 32'h340, 0);
    lm.send(r, 1);
    outs({2'b01, ~r[7:0]}, 0);
    // Channel off ignores the link
    apb(1, 12'h000, 32'ha40, 0);
    lm.send(r, 1);
    outs({2'b01, ~r[7:0]}, 0);
    // Ten-bit reference mode, empty FIFO reports underrun kind
    apb(1, 12'h000, 32'h041, 0);
    repeat (20) @(posedge pclk);
    outs(10'h102, 1);
    // Drop sync with channel off returns alignment to hunt
    apb(1, 12'h000, 32'h1a40, 0);
    apb(0, 12'h004, 32'h1, 32'hf);
    apb(0, 12'h000, 32'h1a40, '1);
    repeat (5) @(posedge pclk);
    conclude;
  end
endmodule

`default_nettype wire
